// >>> src/dbr_pkg.sv
// shared constants and types of the delayed dual-button reset generator
// assumes a single 125 MHz clock; all times are turned into cycle counts here
package dbr_pkg;

  // ******************************************************************
  // clock and timing
  // ******************************************************************
  localparam int unsigned CLK_KHZ              = 125_000;
  localparam int unsigned HOLD_STEP_MS         = 500;
  localparam int unsigned HOLD_STEPS_MIN       = 1;
  localparam int unsigned HOLD_STEPS_MAX       = 20;
  localparam int unsigned HOLD_STEPS_DEF       = 15;
  localparam int unsigned HOLD_STEP_CYCLES     = HOLD_STEP_MS * CLK_KHZ;
  localparam int unsigned HOLD_CYCLES_DEF      = HOLD_STEPS_DEF * HOLD_STEP_CYCLES;
  localparam int unsigned PULSE_MS_DEF         = 100;
  localparam int unsigned PULSE_CYCLES_DEF     = PULSE_MS_DEF * CLK_KHZ;
  localparam int unsigned TEST_ENTRY_MS        = 42;
  localparam int unsigned TEST_ENTRY_CYCLES_DEF = TEST_ENTRY_MS * CLK_KHZ;
  localparam int unsigned TEST_HOLD_MS         = 21;
  localparam int unsigned TEST_HOLD_CYCLES_DEF = TEST_HOLD_MS * CLK_KHZ;
  localparam int unsigned CNT_W                = 32;
  typedef logic [CNT_W-1:0] dbr_cnt_t;

  // ******************************************************************
  // register bus
  // ******************************************************************
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam logic [7:0]  STATUS_OFS   = 8'h00;
  localparam logic [7:0]  CTRL_OFS     = 8'h04;
  localparam logic [7:0]  CONFIG_OFS   = 8'h08;
  localparam int unsigned ST_RST_BIT   = 0;
  localparam int unsigned ST_TEST_BIT  = 1;
  localparam int unsigned ST_PRI_BIT   = 2;
  localparam int unsigned ST_SEC_BIT   = 3;
  localparam int unsigned ST_LOW_BIT   = 4;
  localparam int unsigned ST_TLVL_BIT  = 5;
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam logic        CTRL_EN_RST  = 1'h1;
  localparam int unsigned CFG_STEPS_W  = 5;
  localparam int unsigned CFG_FIXED_BIT = 8;
  localparam int unsigned CFG_AHIGH_BIT = 9;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ******************************************************************
  // input synchroniser
  // ******************************************************************
  localparam int unsigned IN_W     = 4;
  localparam int unsigned IN_PRI   = 0;
  localparam int unsigned IN_SEC   = 1;
  localparam int unsigned IN_TLVL  = 2;
  localparam int unsigned IN_LOW   = 3;
  localparam logic [3:0]  SYNC_RST = 4'h3;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ARM,
    S_BTN,
    S_PULSE,
    S_TENTRY,
    S_TLEVEL,
    S_WAIT
  } dbr_state_t;

endpackage

// >>> src/dbr_in_if.sv
// synchronised input levels passed from the synchroniser to the core
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface dbr_in_if;
  logic primary_act;
  logic secondary_act;
  logic test_level;
  logic supply_low;
  modport drv  (output primary_act, output secondary_act, output test_level, output supply_low);
  modport core (input primary_act, input secondary_act, input test_level, input supply_low);
endinterface

// >>> src/dbr_insync.sv
// two-stage synchroniser for the pin-level inputs
// assumes raw pins are asynchronous to aclk; buttons arrive active low
`timescale 1ns/1ps
module dbr_insync
  import dbr_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic primary_button_input_n,
  input  wire logic secondary_button_input_n,
  input  wire logic test_entry_level,
  input  wire logic supply_low,
  dbr_in_if.drv     sig
);

  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
  } dbr_sync_t;

  dbr_sync_t       cur;
  dbr_sync_t       next_cur;
  logic [IN_W-1:0] raw;

  assign raw = {supply_low, test_entry_level, secondary_button_input_n, primary_button_input_n};

  // first stage feeds only the second stage
  always_comb begin
    next_cur    = cur;
    next_cur.s1 = raw;
    next_cur.s2 = cur.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= {SYNC_RST, SYNC_RST};
    end else begin
      cur <= next_cur;
    end
  end

  assign sig.primary_act   = ~cur.s2[IN_PRI];
  assign sig.secondary_act = ~cur.s2[IN_SEC];
  assign sig.test_level    = cur.s2[IN_TLVL];
  assign sig.supply_low    = cur.s2[IN_LOW];

endmodule

// >>> src/dbr_top.sv
// delayed dual-button reset generator with AXI4-Lite status and control
// assumes one 125 MHz clock; pins are synchronised inside; supply_low and
// test_entry_level come from analogue comparators outside this block
//
// Function
// - a button reset asserts only after both buttons held together for the hold delay
// - hold delay is a build-time constant, 0.5 s to 10 s in 0.5 s steps
// - button-released option: reset stays until one button is released
// - fixed-pulse option: reset lasts exactly the pulse duration
// - fixed pulse length ignores button state after assertion
// - reset output polarity chosen at build time
// - both buttons active low; test entry has its own test_entry_level pin
// - supply low ignores buttons and holds reset deasserted
// - test-entry level starts a 42 ms initial delay
// - at its end reset asserts for pulse, or while overvoltage stays
// - in test mode a 21 ms hold delay replaces the normal one
// - test mode stays latched until a full power cycle
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module dbr_top #(
  parameter int unsigned HOLD_STEPS        = dbr_pkg::HOLD_STEPS_DEF,
  parameter logic        FIXED_PULSE       = 1'h0,
  parameter logic        ACTIVE_HIGH       = 1'h0,
  parameter int unsigned HOLD_CYCLES       = HOLD_STEPS * dbr_pkg::HOLD_STEP_CYCLES,
  parameter int unsigned PULSE_CYCLES      = dbr_pkg::PULSE_CYCLES_DEF,
  parameter int unsigned TEST_ENTRY_CYCLES = dbr_pkg::TEST_ENTRY_CYCLES_DEF,
  parameter int unsigned TEST_HOLD_CYCLES  = dbr_pkg::TEST_HOLD_CYCLES_DEF
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         primary_button_input_n,
  input  wire logic                         secondary_button_input_n,
  input  wire logic                         test_entry_level,
  input  wire logic                         supply_low,
  output logic                              rst_out,
  input  wire logic [dbr_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [dbr_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [dbr_pkg::DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [dbr_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [dbr_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready
);
  import dbr_pkg::*;

  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    dbr_state_t        state;
    dbr_cnt_t          cnt;
    logic              test_mode;
    logic              rst_active;
    logic              rst_level;
    logic              btn_enable;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } dbr_top_state_t;

  localparam logic     ACT_LVL     = ACTIVE_HIGH;
  localparam dbr_cnt_t PULSE_LAST  = dbr_cnt_t'(PULSE_CYCLES - 1);
  localparam dbr_cnt_t ENTRY_LAST  = dbr_cnt_t'(TEST_ENTRY_CYCLES - 1);
  localparam dbr_cnt_t THOLD_LAST  = dbr_cnt_t'(TEST_HOLD_CYCLES - 1);
  localparam dbr_cnt_t NHOLD_LAST  = dbr_cnt_t'(HOLD_CYCLES - 1);

  dbr_top_state_t cur;
  dbr_top_state_t next_cur;
  dbr_cnt_t       hold_last;
  logic           both_act;
  logic           wr_go;
  logic           rd_go;
  logic [7:0]     wr_addr;
  logic [7:0]     rd_addr;

  dbr_in_if sig ();

  dbr_insync u_insync (
    .aclk                     (aclk),
    .aresetn                  (aresetn),
    .primary_button_input_n   (primary_button_input_n),
    .secondary_button_input_n (secondary_button_input_n),
    .test_entry_level         (test_entry_level),
    .supply_low               (supply_low),
    .sig                      (sig)
  );

  // ******************************************************************
  // combinational helpers and bus handshakes
  // ******************************************************************
  // buttons count as pressed only while both are low and software allows them
  assign both_act  = sig.primary_act & sig.secondary_act & cur.btn_enable;
  assign hold_last = cur.test_mode ? THOLD_LAST : NHOLD_LAST;
  // address and data are taken together; bresp is held until bready
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~cur.bvalid;
  assign rd_go         = s_axi_arvalid & ~cur.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign wr_addr       = {s_axi_awaddr[7:2], 2'h0};
  assign rd_addr       = {s_axi_araddr[7:2], 2'h0};

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    next_cur = cur;
    case (cur.state)
      S_IDLE: begin
        next_cur.cnt        = '0;
        next_cur.rst_active = 1'h0;
        if (sig.test_level && !cur.test_mode) begin
          next_cur.state = S_TENTRY;
        end else if (both_act) begin
          next_cur.state = S_ARM;
        end
      end
      S_ARM: begin
        if (!both_act) begin
          next_cur.state = S_IDLE;
          next_cur.cnt   = '0;
        end else if (cur.cnt == hold_last) begin
          next_cur.cnt        = '0;
          next_cur.rst_active = 1'h1;
          next_cur.state      = FIXED_PULSE ? S_PULSE : S_BTN;
        end else begin
          next_cur.cnt = cur.cnt + 32'h1;
        end
      end
      S_BTN: begin
        // no minimum width: a release ends the pulse at once
        if (!both_act) begin
          next_cur.rst_active = 1'h0;
          next_cur.state      = S_IDLE;
        end
      end
      S_PULSE: begin
        // buttons are not looked at until the pulse is over
        if (cur.cnt == PULSE_LAST) begin
          next_cur.cnt        = '0;
          next_cur.rst_active = 1'h0;
          next_cur.state      = S_WAIT;
        end else begin
          next_cur.cnt = cur.cnt + 32'h1;
        end
      end
      S_TENTRY: begin
        if (!sig.test_level) begin
          next_cur.state = S_IDLE;
          next_cur.cnt   = '0;
        end else if (cur.cnt == ENTRY_LAST) begin
          next_cur.cnt        = '0;
          next_cur.test_mode  = 1'h1;
          next_cur.rst_active = 1'h1;
          next_cur.state      = FIXED_PULSE ? S_PULSE : S_TLEVEL;
        end else begin
          next_cur.cnt = cur.cnt + 32'h1;
        end
      end
      S_TLEVEL: begin
        if (!sig.test_level) begin
          next_cur.rst_active = 1'h0;
          next_cur.state      = S_IDLE;
        end
      end
      S_WAIT: begin
        // a held press after a fixed pulse must not retrigger at once
        if (!both_act && !sig.test_level) begin
          next_cur.state = S_IDLE;
        end
      end
      default: begin
        next_cur.state      = S_IDLE;
        next_cur.cnt        = '0;
        next_cur.rst_active = 1'h0;
      end
    endcase
    // low supply aborts a pending entry too, but an already latched test mode stays
    if (sig.supply_low) begin
      next_cur.test_mode  = cur.test_mode;
      next_cur.state      = S_IDLE;
      next_cur.cnt        = '0;
      next_cur.rst_active = 1'h0;
    end
    next_cur.rst_level = next_cur.rst_active ? ACT_LVL : ~ACT_LVL;

    // write channel
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'h0;
    end
    if (wr_go) begin
      next_cur.bvalid = 1'h1;
      next_cur.bresp  = RESP_OKAY;
      if (wr_addr == CTRL_OFS) begin
        if (s_axi_wstrb[0]) begin
          next_cur.btn_enable = s_axi_wdata[CTRL_EN_BIT];
        end
      end else if (wr_addr != STATUS_OFS && wr_addr != CONFIG_OFS) begin
        next_cur.bresp = RESP_SLVERR;
      end
    end

    // read channel
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'h0;
    end
    if (rd_go) begin
      next_cur.rvalid = 1'h1;
      next_cur.rresp  = RESP_OKAY;
      next_cur.rdata  = '0;
      case (rd_addr)
        STATUS_OFS: begin
          next_cur.rdata[ST_RST_BIT]  = cur.rst_active;
          next_cur.rdata[ST_TEST_BIT] = cur.test_mode;
          next_cur.rdata[ST_PRI_BIT]  = sig.primary_act;
          next_cur.rdata[ST_SEC_BIT]  = sig.secondary_act;
          next_cur.rdata[ST_LOW_BIT]  = sig.supply_low;
          next_cur.rdata[ST_TLVL_BIT] = sig.test_level;
        end
        CTRL_OFS: begin
          next_cur.rdata[CTRL_EN_BIT] = cur.btn_enable;
        end
        CONFIG_OFS: begin
          next_cur.rdata[CFG_STEPS_W-1:0] = CFG_STEPS_W'(HOLD_STEPS);
          next_cur.rdata[CFG_FIXED_BIT]   = FIXED_PULSE;
          next_cur.rdata[CFG_AHIGH_BIT]   = ACTIVE_HIGH;
        end
        default: begin
          next_cur.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ******************************************************************
  // registers
  // ******************************************************************
  // aresetn stands for a power cycle: it is the only way out of test mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur            <= '0;
      cur.state      <= S_IDLE;
      cur.rst_level  <= ~ACT_LVL;
      cur.btn_enable <= CTRL_EN_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign rst_out      = cur.rst_level;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp  = cur.bresp;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata  = cur.rdata;
  assign s_axi_rresp  = cur.rresp;

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking dbr_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_hold_done;
    $rose(cur.rst_active) && $past(cur.state) == S_ARM && !$past(cur.test_mode)
      |-> $past(cur.cnt) == NHOLD_LAST;
  endproperty
  a_hold_done: assert property (p_hold_done) else $error("reset before hold delay");

  property p_test_hold;
    $rose(cur.rst_active) && $past(cur.state) == S_ARM && $past(cur.test_mode)
      |-> $past(cur.cnt) == THOLD_LAST;
  endproperty
  a_test_hold: assert property (p_test_hold) else $error("test hold delay wrong");

  property p_release;
    cur.state == S_BTN && !both_act && !sig.supply_low |=> !cur.rst_active;
  endproperty
  a_release: assert property (p_release) else $error("reset kept after release");

  property p_pulse_hold;
    cur.state == S_PULSE && cur.cnt != PULSE_LAST && !sig.supply_low
      |=> cur.rst_active && cur.state == S_PULSE;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("fixed pulse cut short");

  property p_pulse_end;
    cur.state == S_PULSE && cur.cnt == PULSE_LAST |=> !cur.rst_active;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("fixed pulse too long");

  property p_polarity;
    rst_out == (cur.rst_active ? ACT_LVL : ~ACT_LVL);
  endproperty
  a_polarity: assert property (p_polarity) else $error("reset output polarity wrong");

  property p_arm;
    cur.state == S_IDLE && both_act && !sig.supply_low && !sig.test_level
      |=> cur.state == S_ARM;
  endproperty
  a_arm: assert property (p_arm) else $error("press not armed");

  property p_supply;
    sig.supply_low |=> !cur.rst_active && cur.state == S_IDLE;
  endproperty
  a_supply: assert property (p_supply) else $error("reset active at low supply");

  property p_entry;
    $rose(cur.test_mode) |-> cur.rst_active && $past(cur.cnt) == ENTRY_LAST;
  endproperty
  a_entry: assert property (p_entry) else $error("test entry timing wrong");

  property p_latched;
    $past(cur.test_mode) |-> cur.test_mode;
  endproperty
  a_latched: assert property (p_latched) else $error("test mode left early");

  property p_discard;
    cur.state == S_ARM && !both_act && !sig.supply_low |=> cur.state == S_IDLE && cur.cnt == '0;
  endproperty
  a_discard: assert property (p_discard) else $error("count kept after release");

  c_btn_reset: cover property ($rose(cur.rst_active) && $past(cur.state) == S_ARM);
  c_test_entry: cover property ($rose(cur.test_mode));
  c_early_release: cover property (cur.state == S_ARM ##1 cur.state == S_IDLE);

endmodule

// >>> verif/dbr_partner.sv
// push-button pair and processor reset input, seen from the generator
// assumes commands change by non-blocking assignment after aclk rises
`timescale 1ns/1ps
module dbr_partner (
  input  wire logic aclk,
  input  wire logic press_pri,
  input  wire logic press_sec,
  input  wire logic overvolt,
  input  wire logic rst_seen,
  output logic      primary_button_input_n,
  output logic      secondary_button_input_n,
  output logic      test_entry_level,
  output int        pulse_len
);
  int run = 0;
  int last = 0;

  // pull-ups: an open button reads high, never its last driven level
  assign primary_button_input_n   = !press_pri;
  assign secondary_button_input_n = !press_sec;
  assign test_entry_level         = overvolt;

  // processor side: width of the last active-high reset pulse
  assign pulse_len = last;
  always @(posedge aclk) begin
    if (rst_seen) begin
      run <= run + 1;
    end else begin
      if (run != 0) last <= run;
      run <= 0;
    end
  end
endmodule

// >>> verif/dbr_top_tb.sv
// self-checking bench: two generators, one per pulse option, on one bus
// assumes shortened counts; the fixed-pulse copy sees the same bus traffic
`timescale 1ns/1ps
module dbr_top_tb;
  import dbr_pkg::*;
  localparam int HC = 20;
  localparam int PC = 8;
  localparam int TE = 12;
  localparam int TH = 6;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic        press_pri = 0;
  logic        press_sec = 0;
  logic        overv = 0;
  logic        supply_low = 0;
  logic        pri_n, sec_n, tlvl, rst_a, rst_b;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          pulse_len;
  int          mismatches = 0;
  int          num_checks = 0;
  int          n;

  always #4 aclk = ~aclk;

  dbr_top #(.HOLD_CYCLES(HC), .PULSE_CYCLES(PC), .TEST_ENTRY_CYCLES(TE),
    .TEST_HOLD_CYCLES(TH)) dbr_top_i (
    .aclk(aclk), .aresetn(aresetn), .primary_button_input_n(pri_n),
    .secondary_button_input_n(sec_n), .test_entry_level(tlvl),
    .supply_low(supply_low), .rst_out(rst_a), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  dbr_top #(.HOLD_CYCLES(HC), .PULSE_CYCLES(PC), .TEST_ENTRY_CYCLES(TE),
    .TEST_HOLD_CYCLES(TH), .FIXED_PULSE(1'h1), .ACTIVE_HIGH(1'h1)) dbr_top_fixed_i (
    .aclk(aclk), .aresetn(aresetn), .primary_button_input_n(pri_n),
    .secondary_button_input_n(sec_n), .test_entry_level(tlvl),
    .supply_low(supply_low), .rst_out(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready));

  dbr_partner dbr_partner_i (
    .aclk(aclk), .press_pri(press_pri), .press_sec(press_sec), .overvolt(overv),
    .rst_seen(rst_b), .primary_button_input_n(pri_n),
    .secondary_button_input_n(sec_n), .test_entry_level(tlvl),
    .pulse_len(pulse_len));

  // ******************************************************************
  // helpers
  // ******************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tmo();
    mismatches++;
    finish_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (++t > 50) tmo();
    end while ((awready && wready) !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin
      @(posedge aclk);
      if (++t > 50) tmo();
    end while (bvalid !== 1'b1);
    chk_resp(bresp, er);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (++t > 50) tmo();
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      if (++t > 50) tmo();
    end while (rvalid !== 1'b1);
    chk(rdata, ed);
    chk_resp(rresp, er);
    rready <= 1'b0;
  endtask

  task automatic press(input logic p, input logic s);
    @(posedge aclk);
    press_pri <= p;
    press_sec <= s;
  endtask

  // edges from the launching edge until the active-low output reaches lvl
  task automatic wait_rst(input logic lvl, output int cnt);
    cnt = 0;
    while (rst_a !== lvl) begin
      @(posedge aclk);
      #1;
      if (++cnt > 400) tmo();
    end
  endtask

  task automatic quiet(input int cyc);
    repeat (cyc) begin
      @(posedge aclk);
      #1;
      chk(rst_a, 32'h1);
      chk(rst_b, 32'h0);
    end
  endtask

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(rst_a, 32'h1);
    chk(rst_b, 32'h0);
    axi_rd(CONFIG_OFS, 32'h0000000F, RESP_OKAY);
    axi_rd(CTRL_OFS, 32'h00000001, RESP_OKAY);
    axi_rd(8'h0C, 32'h00000000, RESP_SLVERR);
    axi_wr(STATUS_OFS, 32'h00000000, RESP_OKAY);
    axi_wr(8'h10, 32'h00000000, RESP_SLVERR);
    $display("test registers done");

    press(1, 1);
    wait_rst(1'b0, n);
    chk(n, HC + 3);
    repeat (12) @(posedge aclk);
    chk(pulse_len, PC);
    press(1, 0);
    wait_rst(1'b1, n);
    chk(n, 3);
    press(0, 0);
    press(1, 1);
    repeat (15) @(posedge aclk);
    press(1, 0);
    repeat (4) @(posedge aclk);
    press(1, 1);
    wait_rst(1'b0, n);
    chk(n, HC + 3);
    press(0, 0);
    wait_rst(1'b1, n);
    // the fixed copy runs its pulse to the end although the buttons were let go
    repeat (PC) @(posedge aclk);
    chk(pulse_len, PC);
    $display("test hold done");

    press(1, 0);
    quiet(40);
    press(0, 1);
    quiet(40);
    press(0, 0);
    axi_wr(CTRL_OFS, 32'h00000000, RESP_OKAY);
    axi_rd(CTRL_OFS, 32'h00000000, RESP_OKAY);
    press(1, 1);
    quiet(40);
    press(0, 0);
    axi_wr(CTRL_OFS, 32'h00000001, RESP_OKAY);
    press(1, 1);
    wait_rst(1'b0, n);
    @(posedge aclk);
    supply_low <= 1'b1;
    wait_rst(1'b1, n);
    chk(n, 3);
    press(0, 0);
    press(1, 1);
    quiet(40);
    press(0, 0);
    @(posedge aclk);
    supply_low <= 1'b0;
    $display("test ignore done");

    @(posedge aclk);
    overv <= 1'b1;
    wait_rst(1'b0, n);
    chk(n, TE + 3);
    repeat (20) @(posedge aclk);
    #1;
    chk(rst_a, 32'h0);
    chk(pulse_len, PC);
    axi_rd(STATUS_OFS, 32'h00000023, RESP_OKAY);
    @(posedge aclk);
    overv <= 1'b0;
    wait_rst(1'b1, n);
    chk(n, 3);
    repeat (2) begin
      repeat (4) @(posedge aclk);
      press(1, 1);
      wait_rst(1'b0, n);
      chk(n, TH + 3);
      press(0, 0);
      wait_rst(1'b1, n);
    end
    // power cycle is the only way out of test mode
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(STATUS_OFS, 32'h00000000, RESP_OKAY);
    press(1, 1);
    wait_rst(1'b0, n);
    chk(n, HC + 3);
    press(0, 0);
    wait_rst(1'b1, n);
    $display("test mode done");
    finish_test();
  end
endmodule
